/* File: src/tpc_consts.vh */
// Notes on behaviour
// - Reset clears both bytes of the channel value register.
// - In capture mode, reading one value byte freezes both until the other is read.
// - Writing channel status/control releases a pending capture read latch.
// - In compare/PWM modes value bytes buffer; both written moves the 16-bit value.
// - Writing channel status/control discards a half-written channel value.
// - Clock source field resets to 00 (off); 01 selects the bus clock.
// - Clock source is off, bus clock, fixed clock tick or external input.
// - Counting pauses in debug halt and stop mode; runs on in wait mode.
// - Center-aligned select makes the counter up/down and the channel center PWM.
// - Up-counting runs 0x0000 to terminal count (modulus or 0xFFFF) then wraps.
// - Up/down runs 0 to modulus and back, each endpoint one tick long.
// - Overflow request is a level while flag and its enable are both 1.
// - Up-counting sets overflow flag on the terminal count to 0x0000 step.
// - Up/down sets overflow flag when stepping down from the modulus value.
// - Reading a counter byte freezes both bytes until both have been read.
// - Writing either counter byte resets the counter and its read latch.
// - Without center-aligned select, mode bits pick capture, compare or edge PWM.
// - Edge/level 00 frees pin; mode 00 capture edges, 01 compare, 1X edge PWM.
// - Edge PWM moves a complete buffered value only while the counter is 0x0000.
// - A capture latches the counter into the channel value and sets the flag.
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH

// Register byte offsets
`define TPC_OFF_TSC 6'h00
`define TPC_OFF_CNTH 6'h04
`define TPC_OFF_CNTL 6'h08
`define TPC_OFF_MODH 6'h0C
`define TPC_OFF_MODL 6'h10
`define TPC_OFF_CSC 6'h14
`define TPC_OFF_CVH 6'h18
`define TPC_OFF_CVL 6'h1C
`define TPC_ADDR_ZERO 6'h00

// Bus transfer size of a whole word
`define TPC_HSIZE_WORD 3'h2

// Timer status/control fields
`define TPC_TSC_TOF 7
`define TPC_TSC_OVERFLOW_INTERRUPT_ENABLE 6
`define TPC_TSC_CENTER_ALIGNED_SELECT 5
`define TPC_TSC_CLKS_HI 4
`define TPC_TSC_CLKS_LO 3

// Channel status/control fields
`define TPC_CSC_FLAG 7
`define TPC_CSC_IE 6
`define TPC_CSC_MSB 5
`define TPC_CSC_MSA 4
`define TPC_CSC_ELSB 3
`define TPC_CSC_ELSA 2

// Clock source codes
`define TPC_CLK_OFF 2'h0
`define TPC_CLK_BUS 2'h1
`define TPC_CLK_FIXED 2'h2
`define TPC_CLK_EXT 2'h3

// Edge/level codes
`define TPC_ELS_NONE 2'h0
`define TPC_ELS_RISE 2'h1
`define TPC_ELS_FALL 2'h2
`define TPC_ELS_BOTH 2'h3

// Values
`define TPC_CNT_ZERO 16'h0000
`define TPC_CNT_MAX 16'hFFFF
`define TPC_CNT_ONE 16'h0001
`define TPC_BYTE_ZERO 8'h00
`define TPC_WORD_ZERO 32'h00000000

`endif

/* File: src/tpc_core.v */
`timescale 1ns/1ps
`include "tpc_consts.vh"

module tpc_core (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire fixed_clk_tick,
	input wire ext_clk_in,
	input wire debug_halt,
	input wire stop_mode,
	input wire chan_pin_in,
	output wire chan_pin_out,
	output wire chan_pin_oe,
	output wire overflow_irq,
	output wire channel_irq
);

////////////////////////////////////////////////////////////////////////////////
// Register state
reg [31:0] hrdata_r;
reg wr_act_r;
reg [5:0] wr_addr_r;
reg overflow_flag_r;
reg overflow_interrupt_enable_r;
reg center_aligned_select_r;
reg [1:0] clock_source_field_r;
reg [15:0] main_counter_r;
reg count_down_r;
reg [15:0] cnt_buf_r;
reg cnt_lat_r;
reg cnt_lat_hi_r;
reg [15:0] modulus_value_r;
reg [15:0] mod_buf_r;
reg mod_hi_wr_r;
reg mod_lo_wr_r;
reg channel_event_flag_r;
reg chan_ie_r;
reg channel_mode_select_b_r;
reg channel_mode_select_a_r;
reg [1:0] edge_level_select_r;
reg [15:0] chan_value_r;
reg [15:0] cv_buf_r;
reg cv_hi_wr_r;
reg cv_lo_wr_r;
reg [15:0] cv_rd_buf_r;
reg cv_lat_r;
reg cv_lat_hi_r;
reg ext_prev_r;
reg pin_prev_r;
reg pin_out_r;

////////////////////////////////////////////////////////////////////////////////
// Bus decode: zero wait states, always OKAY
wire addr_go = hsel & hready & htrans[1];
wire rd_go = addr_go & ~hwrite;
wire [5:0] rd_off = haddr[5:0];
wire wr_tsc = wr_act_r & (wr_addr_r == `TPC_OFF_TSC);
wire wr_cnt = wr_act_r & ((wr_addr_r == `TPC_OFF_CNTH) | (wr_addr_r == `TPC_OFF_CNTL));
wire wr_modh = wr_act_r & (wr_addr_r == `TPC_OFF_MODH);
wire wr_modl = wr_act_r & (wr_addr_r == `TPC_OFF_MODL);
wire wr_csc = wr_act_r & (wr_addr_r == `TPC_OFF_CSC);
wire wr_cvh = wr_act_r & (wr_addr_r == `TPC_OFF_CVH);
wire wr_cvl = wr_act_r & (wr_addr_r == `TPC_OFF_CVL);
wire [7:0] wbyte = hwdata[7:0];
wire rd_cnth = rd_go & (rd_off == `TPC_OFF_CNTH);
wire rd_cntl = rd_go & (rd_off == `TPC_OFF_CNTL);
wire rd_cvh = rd_go & (rd_off == `TPC_OFF_CVH);
wire rd_cvl = rd_go & (rd_off == `TPC_OFF_CVL);

// No wait states and no error: the slave answers every transfer at once
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = hrdata_r;

////////////////////////////////////////////////////////////////////////////////
// Mode decode
wire mode_cpwm = center_aligned_select_r;
wire mode_epwm = ~mode_cpwm & channel_mode_select_b_r;
wire mode_oc = ~mode_cpwm & ~channel_mode_select_b_r & channel_mode_select_a_r;
wire mode_ic = ~mode_cpwm & ~channel_mode_select_b_r & ~channel_mode_select_a_r;
wire pin_used = (edge_level_select_r != `TPC_ELS_NONE);

////////////////////////////////////////////////////////////////////////////////
// Counting tick from the selected source, held off in debug halt and stop
// External input counts on its rising edge, so it must run at no more than half of hclk
wire ext_rise = ext_clk_in & ~ext_prev_r;
reg src_tick;
always @* begin
	case (clock_source_field_r)
		`TPC_CLK_BUS: src_tick = 1'b1;
		`TPC_CLK_FIXED: src_tick = fixed_clk_tick;
		`TPC_CLK_EXT: src_tick = ext_rise;
		default: src_tick = 1'b0;
	endcase
end
// Debug halt and stop mode hold the count; wait mode does not pause it
wire tick = src_tick & ~debug_halt & ~stop_mode;

////////////////////////////////////////////////////////////////////////////////
// Next counter value and overflow detection
// A modulus of zero lets the counter run through the full 16-bit range
wire [15:0] term = (modulus_value_r == `TPC_CNT_ZERO) ? `TPC_CNT_MAX : modulus_value_r;
reg [15:0] cnt_nxt;
reg dir_nxt;
reg ovf_evt;
always @* begin
	cnt_nxt = main_counter_r;
	dir_nxt = count_down_r;
	ovf_evt = 1'b0;
	if (!mode_cpwm) begin
		dir_nxt = 1'b0;
		if (main_counter_r == term) begin
			cnt_nxt = `TPC_CNT_ZERO;
			ovf_evt = 1'b1;
		end else begin
			cnt_nxt = main_counter_r + `TPC_CNT_ONE;
		end
	end else if (!count_down_r) begin
		if (main_counter_r == modulus_value_r) begin
			cnt_nxt = main_counter_r - `TPC_CNT_ONE;
			dir_nxt = 1'b1;
			ovf_evt = 1'b1;
		end else begin
			cnt_nxt = main_counter_r + `TPC_CNT_ONE;
		end
	end else begin
		if (main_counter_r == `TPC_CNT_ZERO) begin
			cnt_nxt = main_counter_r + `TPC_CNT_ONE;
			dir_nxt = 1'b0;
		end else begin
			cnt_nxt = main_counter_r - `TPC_CNT_ONE;
		end
	end
end
// Overflow only counts on a real counting tick
wire ovf_tick = tick & ovf_evt;

////////////////////////////////////////////////////////////////////////////////
// Channel events
wire pin_rise = chan_pin_in & ~pin_prev_r;
wire pin_fall = ~chan_pin_in & pin_prev_r;
reg cap_edge;
always @* begin
	case (edge_level_select_r)
		`TPC_ELS_RISE: cap_edge = pin_rise;
		`TPC_ELS_FALL: cap_edge = pin_fall;
		`TPC_ELS_BOTH: cap_edge = pin_rise | pin_fall;
		default: cap_edge = 1'b0;
	endcase
end
// Capture is edge driven; a compare match needs a counting tick
wire capture = mode_ic & cap_edge;
wire match = tick & ~mode_ic & (main_counter_r == chan_value_r);
wire chan_evt = capture | match;

// Value buffer transfer condition per mode
wire cv_full = cv_hi_wr_r & cv_lo_wr_r;
wire cv_xfer_ok = mode_cpwm ? ovf_tick :
	(mode_epwm ? (main_counter_r == `TPC_CNT_ZERO) : 1'b1);
wire cv_xfer = cv_full & cv_xfer_ok & ~mode_ic;
// Modulus pair: applied at once when up-counting, at the turn in center mode
wire mod_full = mod_hi_wr_r & mod_lo_wr_r;
wire mod_xfer = mod_full & (~mode_cpwm | ovf_tick);

////////////////////////////////////////////////////////////////////////////////
// Read data mux with coherency buffers
wire [15:0] cnt_view = cnt_lat_r ? cnt_buf_r : main_counter_r;
wire [15:0] cv_view = (mode_ic & cv_lat_r) ? cv_rd_buf_r : chan_value_r;
// Unused bits and unmapped offsets read as zero
reg [7:0] rd_byte;
always @* begin
	case (rd_off)
		`TPC_OFF_TSC: rd_byte = {overflow_flag_r, overflow_interrupt_enable_r,
			center_aligned_select_r, clock_source_field_r, 3'h0};
		`TPC_OFF_CNTH: rd_byte = cnt_view[15:8];
		`TPC_OFF_CNTL: rd_byte = cnt_view[7:0];
		`TPC_OFF_MODH: rd_byte = modulus_value_r[15:8];
		`TPC_OFF_MODL: rd_byte = modulus_value_r[7:0];
		`TPC_OFF_CSC: rd_byte = {channel_event_flag_r, chan_ie_r, channel_mode_select_b_r,
			channel_mode_select_a_r, edge_level_select_r, 2'h0};
		`TPC_OFF_CVH: rd_byte = cv_view[15:8];
		`TPC_OFF_CVL: rd_byte = cv_view[7:0];
		default: rd_byte = `TPC_BYTE_ZERO;
	endcase
end

// Bus pipeline: read data at address edge, write address held for data phase
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata_r <= `TPC_WORD_ZERO;
		wr_act_r <= 1'b0;
		wr_addr_r <= `TPC_ADDR_ZERO;
	end else begin
		// Only whole-word writes are kept; the data phase follows
		wr_act_r <= addr_go & hwrite & (hsize == `TPC_HSIZE_WORD);
		wr_addr_r <= haddr[5:0];
		if (rd_go)
			hrdata_r <= {24'h000000, rd_byte};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Timer status/control, counter and modulus
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		overflow_flag_r <= 1'b0;
		overflow_interrupt_enable_r <= 1'b0;
		center_aligned_select_r <= 1'b0;
		clock_source_field_r <= `TPC_CLK_OFF;
		main_counter_r <= `TPC_CNT_ZERO;
		count_down_r <= 1'b0;
		cnt_buf_r <= `TPC_CNT_ZERO;
		cnt_lat_r <= 1'b0;
		cnt_lat_hi_r <= 1'b0;
		modulus_value_r <= `TPC_CNT_ZERO;
		mod_buf_r <= `TPC_CNT_ZERO;
		mod_hi_wr_r <= 1'b0;
		mod_lo_wr_r <= 1'b0;
		ext_prev_r <= 1'b0;
	end else begin
		// Previous external level for edge detection
		ext_prev_r <= ext_clk_in;
		// Control write; flag cleared by writing 1, a new overflow wins
		if (wr_tsc) begin
			overflow_interrupt_enable_r <= wbyte[`TPC_TSC_OVERFLOW_INTERRUPT_ENABLE];
			center_aligned_select_r <= wbyte[`TPC_TSC_CENTER_ALIGNED_SELECT];
			clock_source_field_r <= wbyte[`TPC_TSC_CLKS_HI:`TPC_TSC_CLKS_LO];
			if (wbyte[`TPC_TSC_TOF])
				overflow_flag_r <= 1'b0;
		end
		if (ovf_tick)
			overflow_flag_r <= 1'b1;
		// Counter: a write resets it, otherwise step on each tick
		if (wr_cnt) begin
			main_counter_r <= `TPC_CNT_ZERO;
			count_down_r <= 1'b0;
		end else if (tick) begin
			main_counter_r <= cnt_nxt;
			count_down_r <= dir_nxt;
		end
		// Counter read coherency
		if (wr_cnt) begin
			cnt_lat_r <= 1'b0;
		end else if ((rd_cnth | rd_cntl) & ~cnt_lat_r) begin
			cnt_lat_r <= 1'b1;
			cnt_lat_hi_r <= rd_cnth;
			cnt_buf_r <= main_counter_r;
		end else if (cnt_lat_r & ((rd_cntl & cnt_lat_hi_r) | (rd_cnth & ~cnt_lat_hi_r))) begin
			cnt_lat_r <= 1'b0;
		end
		// Modulus buffer; a control write cancels a partial pair
		if (wr_tsc) begin
			mod_hi_wr_r <= 1'b0;
			mod_lo_wr_r <= 1'b0;
		end else if (mod_xfer) begin
			modulus_value_r <= mod_buf_r;
			mod_hi_wr_r <= 1'b0;
			mod_lo_wr_r <= 1'b0;
		end
		if (wr_modh) begin
			mod_buf_r[15:8] <= wbyte;
			mod_hi_wr_r <= 1'b1;
		end
		if (wr_modl) begin
			mod_buf_r[7:0] <= wbyte;
			mod_lo_wr_r <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Channel status/control and value registers
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		channel_event_flag_r <= 1'b0;
		chan_ie_r <= 1'b0;
		channel_mode_select_b_r <= 1'b0;
		channel_mode_select_a_r <= 1'b0;
		edge_level_select_r <= `TPC_ELS_NONE;
		chan_value_r <= `TPC_CNT_ZERO;
		cv_buf_r <= `TPC_CNT_ZERO;
		cv_hi_wr_r <= 1'b0;
		cv_lo_wr_r <= 1'b0;
		cv_rd_buf_r <= `TPC_CNT_ZERO;
		cv_lat_r <= 1'b0;
		cv_lat_hi_r <= 1'b0;
		pin_prev_r <= 1'b0;
	end else begin
		// Previous pin level; the capture edge compares against it
		pin_prev_r <= chan_pin_in;
		if (wr_csc) begin
			chan_ie_r <= wbyte[`TPC_CSC_IE];
			channel_mode_select_b_r <= wbyte[`TPC_CSC_MSB];
			channel_mode_select_a_r <= wbyte[`TPC_CSC_MSA];
			edge_level_select_r <= wbyte[`TPC_CSC_ELSB:`TPC_CSC_ELSA];
			if (wbyte[`TPC_CSC_FLAG])
				channel_event_flag_r <= 1'b0;
		end
		if (chan_evt)
			channel_event_flag_r <= 1'b1;
		// Write coherency: control write discards a partial value
		if (wr_csc) begin
			cv_hi_wr_r <= 1'b0;
			cv_lo_wr_r <= 1'b0;
		end else if (cv_xfer) begin
			chan_value_r <= cv_buf_r;
			cv_hi_wr_r <= 1'b0;
			cv_lo_wr_r <= 1'b0;
		end
		if (wr_cvh) begin
			cv_buf_r[15:8] <= wbyte;
			cv_hi_wr_r <= 1'b1;
		end
		if (wr_cvl) begin
			cv_buf_r[7:0] <= wbyte;
			cv_lo_wr_r <= 1'b1;
		end
		// A capture is assigned last, so it overrides any buffered transfer
		if (capture)
			chan_value_r <= main_counter_r;
		// Capture read coherency
		if (wr_csc) begin
			cv_lat_r <= 1'b0;
		end else if (mode_ic & (rd_cvh | rd_cvl) & ~cv_lat_r) begin
			cv_lat_r <= 1'b1;
			cv_lat_hi_r <= rd_cvh;
			cv_rd_buf_r <= chan_value_r;
		end else if (cv_lat_r & ((rd_cvl & cv_lat_hi_r) | (rd_cvh & ~cv_lat_hi_r))) begin
			cv_lat_r <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Channel pin output per mode
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		pin_out_r <= 1'b0;
	end else if (mode_cpwm) begin
		if (match)
			pin_out_r <= count_down_r ? ~edge_level_select_r[0] : edge_level_select_r[0];
	end else if (mode_epwm) begin
		// Overflow starts the pulse, a match ends it; the match wins a tie
		if (ovf_tick)
			pin_out_r <= ~edge_level_select_r[0];
		if (match)
			pin_out_r <= edge_level_select_r[0];
	end else if (mode_oc & match) begin
		// Compare action chosen by the edge/level field
		case (edge_level_select_r)
			`TPC_ELS_RISE: pin_out_r <= ~pin_out_r;
			`TPC_ELS_FALL: pin_out_r <= 1'b0;
			`TPC_ELS_BOTH: pin_out_r <= 1'b1;
			default: pin_out_r <= pin_out_r;
		endcase
	end
end

// Pin drive and level-type requests come straight from registers
assign chan_pin_out = pin_out_r;
assign chan_pin_oe = pin_used & ~mode_ic;
assign overflow_irq = overflow_flag_r & overflow_interrupt_enable_r;
assign channel_irq = channel_event_flag_r & chan_ie_r;

endmodule

/* File: tb/tpc_core_properties.sv */
`timescale 1ns/1ps
module tpc_core_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic chan_pin_oe,
	input wire logic overflow_irq,
	input wire logic channel_irq
);
	logic wp_r, rp_r, tt_r, ct_r;
	logic [5:0] ad_r;
	logic [7:0] tsh_r, csh_r;
	wire tk = hsel && hready && htrans[1];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////
	// Track taken transfers and shadow the written control fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			tt_r <= 1'b0;
			ct_r <= 1'b0;
			ad_r <= 6'h00;
			tsh_r <= 8'h00;
			csh_r <= 8'h00;
		end else begin
			wp_r <= tk && hwrite && hsize == 3'h2;
			rp_r <= tk && !hwrite;
			ad_r <= haddr[5:0];
			if (tk && hwrite && haddr[5:0] == 6'h00) begin
				tt_r <= 1'b1;
			end
			if (tk && hwrite && haddr[5:0] >= 6'h14 && haddr[5:0] <= 6'h1C) begin
				ct_r <= 1'b1;
			end
			if (wp_r && ad_r == 6'h00) begin
				tsh_r <= hwdata[7:0];
			end
			if (wp_r && ad_r == 6'h14) begin
				csh_r <= hwdata[7:0];
			end
		end
	end
	////////////////////////////////////////////////////////////////
	property p_tsc_rd;
		rp_r && ad_r == 6'h00 && !$past(wp_r) |-> hrdata[6:3] == tsh_r[6:3];
	endproperty
	a_tsc_rd: assert property (p_tsc_rd) else $error("timer control readback wrong");
	property p_csc_rd;
		rp_r && ad_r == 6'h14 && !$past(wp_r) |-> hrdata[6:2] == csh_r[6:2];
	endproperty
	a_csc_rd: assert property (p_csc_rd) else $error("channel control readback wrong");
	property p_oe;
		chan_pin_oe == (csh_r[3:2] != 2'h0 && (tsh_r[5] || csh_r[5:4] != 2'h0));
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	property p_ovf_en;
		overflow_irq |-> tsh_r[6];
	endproperty
	a_ovf_en: assert property (p_ovf_en) else $error("overflow request unmasked");
	property p_ovf_off;
		wp_r && ad_r == 6'h00 && !hwdata[6] |=> !overflow_irq;
	endproperty
	a_ovf_off: assert property (p_ovf_off) else $error("overflow request stays");
	property p_ch_en;
		channel_irq |-> csh_r[6];
	endproperty
	a_ch_en: assert property (p_ch_en) else $error("channel request unmasked");
	property p_cv_rst;
		rp_r && (ad_r == 6'h18 || ad_r == 6'h1C) && !ct_r |-> hrdata == 32'h0;
	endproperty
	a_cv_rst: assert property (p_cv_rst) else $error("channel value not cleared");
	property p_cnt_off;
		rp_r && (ad_r == 6'h04 || ad_r == 6'h08) && !tt_r |-> hrdata == 32'h0;
	endproperty
	a_cnt_off: assert property (p_cnt_off) else $error("counter moved unclocked");
endmodule
bind tpc_core tpc_core_props tpc_core_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .hrdata, .chan_pin_oe, .overflow_irq, .channel_irq);

/* File: tb/tpc_pins_model.sv */
`timescale 1ns/1ps
module tpc_pins_model (
	input wire logic hclk,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic drv_lvl,
	output logic pin_in,
	output logic ext_clk
);
	logic [1:0] div_r = 2'h0;
	// Pin level: timer drive wins while enabled, else the outside driver
	assign pin_in = pin_oe ? pin_out : drv_lvl;
	// External count clock at a quarter of the bus rate
	always @(posedge hclk) begin
		div_r <= div_r + 2'h1;
	end
	assign ext_clk = div_r[1];
endmodule

/* File: tb/tpc_core_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module tpc_core_tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic debug_halt = 1'b0, stop_mode = 1'b0, drv_lvl = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, tk_r = 3'h0;
	wire hready, hresp, ext_clk_in, chan_pin_in, chan_pin_out, chan_pin_oe;
	wire overflow_irq, channel_irq;
	wire [31:0] hrdata;
	wire fixed_clk_tick = (tk_r == 3'h7);
	int bad_count = 0, check_count = 0;
	always #12.5 hclk = ~hclk;
	always @(posedge hclk) tk_r <= tk_r + 3'h1;
	tpc_core tpc_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .fixed_clk_tick(fixed_clk_tick),
		.ext_clk_in(ext_clk_in), .debug_halt(debug_halt), .stop_mode(stop_mode),
		.chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
		.overflow_irq(overflow_irq), .channel_irq(channel_irq));
	tpc_pins_model tpc_pins_model_i (.hclk(hclk), .pin_out(chan_pin_out),
		.pin_oe(chan_pin_oe), .drv_lvl(drv_lvl), .pin_in(chan_pin_in), .ext_clk(ext_clk_in));
	////////////////////////////////////////////////////////////////
	// One single word transfer: address phase, then data phase
	task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		haddr <= {26'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata[7:0];
	endtask
	// Write, then let buffered transfers settle
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, q);
		repeat (2) @(posedge hclk);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(a, 1'b0, 8'h00, q);
		`CHK({hresp, q}, {1'b0, e}, "read value")
	endtask
	// Counter read, low byte first
	task automatic cnt16(output logic [15:0] v);
		logic [7:0] l, h;
		bus(6'h08, 1'b0, 8'h00, l);
		bus(6'h04, 1'b0, 8'h00, h);
		v = {h, l};
	endtask
	task automatic report_and_stop();
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge hclk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		logic [7:0] a, b, c;
		logic [15:0] u, v;
		int lo[4] = '{0, 81, 9, 19};
		int hi[4] = '{0, 89, 12, 23};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, including one unmapped word
		for (int i = 0; i < 9; i++) begin
			rdc(6'(i * 4), 8'h00);
		end
		// Compare mode value pairs, and a discarded half pair
		wr(6'h14, 8'h10);
		wr(6'h1C, 8'h34);
		rdc(6'h1C, 8'h00);
		wr(6'h18, 8'h12);
		rdc(6'h18, 8'h12);
		rdc(6'h1C, 8'h34);
		wr(6'h1C, 8'h56);
		wr(6'h14, 8'h10);
		wr(6'h18, 8'h78);
		rdc(6'h1C, 8'h34);
		wr(6'h1C, 8'h9A);
		rdc(6'h18, 8'h78);
		// Counter read latch, then counter write clears count and latch
		wr(6'h00, 8'h08);
		bus(6'h08, 1'b0, 8'h00, a);
		bus(6'h08, 1'b0, 8'h00, b);
		`CHK(b, a, "counter latch")
		bus(6'h04, 1'b0, 8'h00, c);
		bus(6'h08, 1'b0, 8'h00, b);
		`CHK(b !== a, 1'b1, "counter latch release")
		wr(6'h00, 8'h00);
		bus(6'h08, 1'b0, 8'h00, a);
		wr(6'h04, 8'hA5);
		rdc(6'h08, 8'h00);
		rdc(6'h04, 8'h00);
		// Debug halt and stop mode freeze the count
		wr(6'h00, 8'h08);
		for (int i = 0; i < 2; i++) begin
			debug_halt <= (i == 0);
			stop_mode <= (i == 1);
			repeat (2) @(posedge hclk);
			cnt16(u);
			repeat (20) @(posedge hclk);
			cnt16(v);
			`CHK(v, u, "count moved while paused")
		end
		debug_halt <= 1'b0;
		stop_mode <= 1'b0;
		// Count rate of each clock source
		for (int s = 0; s < 4; s++) begin
			wr(6'h00, {3'h0, 2'(s), 3'h0});
			cnt16(u);
			repeat (80) @(posedge hclk);
			cnt16(v);
			v = v - u;
			`CHK(v >= lo[s] && v <= hi[s], 1'b1, "count rate")
		end
		// Modulus wrap and overflow flag, up and up/down
		wr(6'h0C, 8'h00);
		wr(6'h10, 8'h09);
		foreach (hi[m]) begin
			if (m < 2) begin
				wr(6'h00, m ? 8'hE8 : 8'hC8);
				wr(6'h04, 8'h00);
				for (int k = 0; k < 6; k++) begin
					cnt16(v);
					`CHK(v <= 16'h0009, 1'b1, "count beyond modulus")
				end
				rdc(6'h00, m ? 8'hE8 : 8'hC8);
				`CHK(overflow_irq, 1'b1, "overflow request")
				wr(6'h00, 8'h88);
				`CHK(overflow_irq, 1'b0, "overflow request masked")
			end
		end
		wr(6'h0C, 8'h00);
		wr(6'h10, 8'h00);
		// Capture on rising edge, read freeze and release by control write
		wr(6'h14, 8'h44);
		drv_lvl <= 1'b1;
		repeat (4) @(posedge hclk);
		`CHK(channel_irq, 1'b1, "capture request")
		bus(6'h1C, 1'b0, 8'h00, a);
		drv_lvl <= 1'b0;
		repeat (3) @(posedge hclk);
		drv_lvl <= 1'b1;
		repeat (4) @(posedge hclk);
		bus(6'h1C, 1'b0, 8'h00, b);
		`CHK(b, a, "capture latch")
		bus(6'h18, 1'b0, 8'h00, c);
		bus(6'h1C, 1'b0, 8'h00, c);
		`CHK(c !== a, 1'b1, "capture latch release")
		drv_lvl <= 1'b0;
		repeat (3) @(posedge hclk);
		drv_lvl <= 1'b1;
		repeat (4) @(posedge hclk);
		wr(6'h14, 8'hC4);
		bus(6'h1C, 1'b0, 8'h00, b);
		`CHK(b !== c, 1'b1, "control write frees latch")
		`CHK(channel_irq, 1'b0, "capture flag cleared")
		// Falling-edge capture ignores the level the pin already sits at
		wr(6'h14, 8'h88);
		rdc(6'h14, 8'h08);
		drv_lvl <= 1'b0;
		repeat (3) @(posedge hclk);
		rdc(6'h14, 8'h88);
		// Output compare set, clear and toggle at a value of 0x0010
		wr(6'h14, 8'h1C);
		wr(6'h18, 8'h00);
		wr(6'h1C, 8'h10);
		wr(6'h04, 8'h00);
		repeat (20) @(posedge hclk);
		`CHK(chan_pin_out, 1'b1, "compare set")
		wr(6'h14, 8'h18);
		wr(6'h04, 8'h00);
		repeat (20) @(posedge hclk);
		`CHK(chan_pin_out, 1'b0, "compare clear")
		wr(6'h14, 8'h14);
		wr(6'h04, 8'h00);
		repeat (20) @(posedge hclk);
		`CHK(chan_pin_out, 1'b1, "compare toggle")
		// Reset in mid-run clears the channel value again
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(6'h18, 8'h00);
		rdc(6'h1C, 8'h00);
		report_and_stop();
	end
endmodule
